// ---- hw/fault_trace_capture.sv ----
// Fault trace recorder: circular capture, trigger logic and readout
// ***************************************************************
// Overview of operation
// - After power-up the recorder is armed with usable defaults and needs no setup.
// - A drive fault or a met trigger condition fires the recorder and freezes its data.
// - After firing it stays disarmed until a fault reset or a power cycle re-arms it.
// - The sample rate code selects 16k, 4k or 1k samples per second for codes 0, 1, 2.
// - Mode 0 is off, 1 fires on any fault, 2 on one chosen fault, 3 on a signal condition.
// - In chosen-fault mode only the exact fault code with sub-code supplied fires it.
// - In condition mode a chosen channel is compared with a 16-bit level on a chosen edge.
// - The trigger sits at a set percentage of the window, 75 by default, with history kept.
// - Readout covers a selection of one to four channels, or all channels at once.
// ***************************************************************
`timescale 1ns/1ps
module fault_trace_capture #(
   parameter int NCH      = 8,
   parameter int DEPTH    = 256,
   parameter int DIV_FAST = trace_pkg::DIV_FAST,
   parameter int DIV_MED  = trace_pkg::DIV_MED,
   parameter int DIV_SLOW = trace_pkg::DIV_SLOW,
   localparam int SW      = $clog2(NCH),
   localparam int AW      = $clog2(DEPTH)
) (
   input  wire logic                          MCLK,
   input  wire logic                          NRST,
   input  wire logic [NCH*trace_pkg::CHAN_W-1:0] CHAN_DATA,
   input  wire logic                          FAULT_EVT,
   input  wire logic [trace_pkg::CODE_W-1:0]  FAULT_CODE,
   input  wire logic                          FAULT_RESET,
   input  wire logic                          CFG_LOAD,
   input  wire logic [1:0]                    CFG_RATE,
   input  wire logic [1:0]                    CFG_MODE,
   input  wire logic [trace_pkg::CODE_W-1:0]  CFG_FAULT,
   input  wire logic [SW-1:0]                 CFG_SRC,
   input  wire logic [trace_pkg::CHAN_W-1:0]  CFG_LEVEL,
   input  wire logic                          CFG_EDGE,
   input  wire logic [trace_pkg::POS_W-1:0]   CFG_POS,
   input  wire logic                          CLEAR,
   input  wire logic                          RD_REQ,
   input  wire logic                          RD_ALL,
   input  wire logic [NCH-1:0]                RD_SEL,
   input  wire logic                          RD_READY,
   output logic                               RD_VALID,
   output logic [trace_pkg::CHAN_W-1:0]       RD_DATA,
   output logic [SW-1:0]                      RD_CHAN,
   output logic [AW-1:0]                      RD_INDEX,
   output logic                               RD_LAST,
   output logic                               RD_REJECT,
   output logic                               ARMED,
   output logic                               CAPTURED
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      trace_pkg::state_t            state;
      logic [1:0]                   rate;
      logic [1:0]                   mode;
      logic [trace_pkg::CODE_W-1:0] fault;
      logic [SW-1:0]                src;
      logic [trace_pkg::CHAN_W-1:0] level;
      logic                         edge_sel;
      logic [trace_pkg::POS_W-1:0]  pos;
      logic [AW-1:0]                wp;
      logic [AW:0]                  fill;
      logic [AW:0]                  post;
      logic                         above_prev;
      logic                         prev_ok;
      logic                         captured;
      logic [NCH-1:0]               mask;
      logic [AW-1:0]                start;
      logic [AW:0]                  rd_idx;
      logic [SW-1:0]                rd_ch;
      logic                         rd_valid;
      logic [trace_pkg::CHAN_W-1:0] rd_data;
      logic [SW-1:0]                rd_chan;
      logic [AW-1:0]                rd_index;
      logic                         rd_last;
      logic                         rd_reject;
   } rec_t;

   localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

   rec_t                          s_reg;
   rec_t                          s_next;
   logic                          rst_meta_reg;
   logic                          rst_n;
   logic                          sample_en;
   logic [NCH*trace_pkg::CHAN_W-1:0] mem [DEPTH];
   logic [NCH*trace_pkg::CHAN_W-1:0] mem_word;
   logic [trace_pkg::CHAN_W-1:0]  src_val;
   logic                          above;
   logic                          cond_hit;
   logic                          fault_hit;
   logic                          fire;
   logic                          store;
   logic [AW:0]                   post_len;
   logic                          sel_ok;

   // ***************************************************************
   // Reset release and sample clock
   // ***************************************************************
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   sample_divider #(
      .CW       (18),
      .DIV_FAST (DIV_FAST),
      .DIV_MED  (DIV_MED),
      .DIV_SLOW (DIV_SLOW)
   ) u_div (
      .clk   (MCLK),
      .rst_n (rst_n),
      .rate  (s_reg.rate),
      .tick  (sample_en)
   );

   // ***************************************************************
   // Trigger terms
   // ***************************************************************
   assign src_val   = CHAN_DATA[s_reg.src*trace_pkg::CHAN_W +: trace_pkg::CHAN_W];
   assign above     = (src_val >= s_reg.level);
   assign cond_hit  = s_reg.prev_ok &&
                      ((s_reg.edge_sel == trace_pkg::EDGE_RISE) ?
                       (above && !s_reg.above_prev) : (!above && s_reg.above_prev));
   assign fault_hit = FAULT_EVT && ((s_reg.mode == trace_pkg::MODE_ANY) ||
                      ((s_reg.mode == trace_pkg::MODE_FAULT) && (FAULT_CODE == s_reg.fault)));
   assign fire      = (s_reg.state == trace_pkg::S_ARMED) && (fault_hit ||
                      ((s_reg.mode == trace_pkg::MODE_COND) && sample_en && cond_hit));
   assign store     = sample_en && (s_reg.mode != trace_pkg::MODE_OFF) &&
                      ((s_reg.state == trace_pkg::S_ARMED) || (s_reg.state == trace_pkg::S_POST));
   // Positions above 100 percent are clamped to a window of pure history
   assign post_len  = DEPTH_W - (AW+1)'((DEPTH * ((int'(s_reg.pos) > trace_pkg::POS_FULL) ?
                      trace_pkg::POS_FULL : int'(s_reg.pos))) / trace_pkg::POS_FULL);
   assign sel_ok    = (s_reg.fill != '0) && (RD_ALL || (($countones(RD_SEL) >= 1) &&
                      ($countones(RD_SEL) <= trace_pkg::MAX_SEL)));
   assign mem_word  = mem[s_reg.start + s_reg.rd_idx[AW-1:0]];

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_next = s_reg;
      s_next.rd_reject = 1'b0;
      if (sample_en) begin
         s_next.above_prev = above;
         s_next.prev_ok    = 1'b1;
      end
      if (store) begin
         s_next.wp = s_reg.wp + 1'b1;
         if (s_reg.fill != DEPTH_W) begin
            s_next.fill = s_reg.fill + 1'b1;
         end
      end
      case (s_reg.state)
         trace_pkg::S_ARMED: begin
            if (fire) begin
               s_next.post = post_len;
               if (post_len == '0) begin
                  s_next.state    = trace_pkg::S_FROZEN;
                  s_next.captured = 1'b1;
               end else begin
                  s_next.state = trace_pkg::S_POST;
               end
            end
         end
         trace_pkg::S_POST: begin
            if (store) begin
               s_next.post = s_reg.post - 1'b1;
               if (s_reg.post == (AW+1)'(1)) begin
                  s_next.state    = trace_pkg::S_FROZEN;
                  s_next.captured = 1'b1;
               end
            end
         end
         trace_pkg::S_FROZEN: begin
            if (CLEAR) begin
               s_next.state    = trace_pkg::S_EMPTY;
               s_next.captured = 1'b0;
            end else if (RD_REQ) begin
               if (sel_ok) begin
                  s_next.state  = trace_pkg::S_READ;
                  s_next.mask   = RD_ALL ? '1 : RD_SEL;
                  s_next.rd_idx = '0;
                  s_next.rd_ch  = '0;
                  s_next.start  = (s_reg.fill == DEPTH_W) ? s_reg.wp : '0;
               end else begin
                  s_next.rd_reject = 1'b1;
               end
            end
         end
         trace_pkg::S_READ: begin
            s_next.rd_valid = s_reg.rd_valid && !RD_READY;
            if (CLEAR) begin
               s_next.state    = trace_pkg::S_EMPTY;
               s_next.captured = 1'b0;
               s_next.rd_valid = 1'b0;
            end else if (s_reg.rd_valid && s_reg.rd_last) begin
               if (RD_READY) begin
                  s_next.state = trace_pkg::S_FROZEN;
               end
            end else if (!s_next.rd_valid) begin
               if (s_reg.mask[s_reg.rd_ch]) begin
                  s_next.rd_valid = 1'b1;
                  s_next.rd_data  = mem_word[s_reg.rd_ch*trace_pkg::CHAN_W +: trace_pkg::CHAN_W];
                  s_next.rd_chan  = s_reg.rd_ch;
                  s_next.rd_index = s_reg.rd_idx[AW-1:0];
                  s_next.rd_last  = ((s_reg.mask >> s_reg.rd_ch) == NCH'(1)) &&
                                    (s_reg.rd_idx == s_reg.fill - 1'b1);
               end
               if (s_reg.rd_ch == SW'(NCH - 1)) begin
                  s_next.rd_ch  = '0;
                  s_next.rd_idx = s_reg.rd_idx + 1'b1;
               end else begin
                  s_next.rd_ch = s_reg.rd_ch + 1'b1;
               end
            end
         end
         trace_pkg::S_EMPTY: begin
            s_next.state = trace_pkg::S_EMPTY;
         end
         default: begin
            s_next.state = trace_pkg::S_ARMED;
         end
      endcase
      // One download replaces the whole trigger setup at once
      if (CFG_LOAD) begin
         s_next.rate     = CFG_RATE;
         s_next.mode     = CFG_MODE;
         s_next.fault    = CFG_FAULT;
         s_next.src      = CFG_SRC;
         s_next.level    = CFG_LEVEL;
         s_next.edge_sel = CFG_EDGE;
         s_next.pos      = CFG_POS;
      end
      // Fault reset wins over everything, including a fire in the same cycle
      if (FAULT_RESET) begin
         s_next.state    = trace_pkg::S_ARMED;
         s_next.wp       = '0;
         s_next.fill     = '0;
         s_next.captured = 1'b0;
         s_next.rd_valid = 1'b0;
         s_next.rd_last  = 1'b0;
         s_next.prev_ok  = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         s_reg          <= '0;
         s_reg.state    <= trace_pkg::S_ARMED;
         s_reg.rate     <= trace_pkg::RATE_RESET;
         s_reg.mode     <= trace_pkg::MODE_RESET;
         s_reg.fault    <= trace_pkg::CODE_RESET;
         s_reg.level    <= trace_pkg::LEVEL_RESET;
         s_reg.edge_sel <= trace_pkg::EDGE_RESET;
         s_reg.pos      <= trace_pkg::POS_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // Buffer memory has no reset; the fill count says what is valid
   always_ff @(posedge MCLK) begin
      if (store) begin
         mem[s_reg.wp] <= CHAN_DATA;
      end
   end

   assign RD_VALID  = s_reg.rd_valid;
   assign RD_DATA   = s_reg.rd_data;
   assign RD_CHAN   = s_reg.rd_chan;
   assign RD_INDEX  = s_reg.rd_index;
   assign RD_LAST   = s_reg.rd_last;
   assign RD_REJECT = s_reg.rd_reject;
   assign ARMED     = (s_reg.state == trace_pkg::S_ARMED);
   assign CAPTURED  = s_reg.captured;

   // ***************************************************************
   // Checks
   // ***************************************************************
   sequence s_cond_rise;
      ARMED && s_reg.mode == trace_pkg::MODE_COND && sample_en && s_reg.prev_ok &&
      s_reg.edge_sel == trace_pkg::EDGE_RISE && above && !s_reg.above_prev && !FAULT_RESET;
   endsequence

   sequence s_cond_fall;
      ARMED && s_reg.mode == trace_pkg::MODE_COND && sample_en && s_reg.prev_ok &&
      s_reg.edge_sel == trace_pkg::EDGE_FALL && !above && s_reg.above_prev && !FAULT_RESET;
   endsequence

   a_armed_at_start: assert property (@(posedge MCLK) $rose(rst_n) |-> ARMED)
      else $error("not armed after reset");
   a_any_fault_fires: assert property (@(posedge MCLK) disable iff (!rst_n)
      (ARMED && s_reg.mode == trace_pkg::MODE_ANY && FAULT_EVT && !FAULT_RESET)
      |=> !ARMED)
      else $error("fault did not fire recorder");
   a_no_self_rearm: assert property (@(posedge MCLK) disable iff (!rst_n)
      (s_reg.state == trace_pkg::S_FROZEN && !FAULT_RESET) |=> !ARMED)
      else $error("recorder re-armed without fault reset");
   a_off_mode_idle: assert property (@(posedge MCLK) disable iff (!rst_n)
      (ARMED && s_reg.mode == trace_pkg::MODE_OFF && !FAULT_RESET)
      |=> ARMED && $stable(s_reg.wp))
      else $error("disabled recorder moved");
   a_wrong_code_ignored: assert property (@(posedge MCLK) disable iff (!rst_n)
      (ARMED && s_reg.mode == trace_pkg::MODE_FAULT && FAULT_EVT &&
       FAULT_CODE != s_reg.fault && !FAULT_RESET) |=> ARMED)
      else $error("non-matching fault fired recorder");
   a_rise_fires: assert property (@(posedge MCLK) disable iff (!rst_n)
      s_cond_rise |=> !ARMED)
      else $error("rising crossing did not fire");
   a_fall_fires: assert property (@(posedge MCLK) disable iff (!rst_n)
      s_cond_fall |=> !ARMED)
      else $error("falling crossing did not fire");
   a_post_window_end: assert property (@(posedge MCLK) disable iff (!rst_n)
      (s_reg.state == trace_pkg::S_POST && store && s_reg.post == (AW+1)'(1) && !FAULT_RESET)
      |=> s_reg.state == trace_pkg::S_FROZEN && CAPTURED)
      else $error("post window did not close");
   a_wide_select_refused: assert property (@(posedge MCLK) disable iff (!rst_n)
      (s_reg.state == trace_pkg::S_FROZEN && RD_REQ && !RD_ALL && !CLEAR && !FAULT_RESET &&
       $countones(RD_SEL) > trace_pkg::MAX_SEL) |=> RD_REJECT && !RD_VALID)
      else $error("too many channels accepted");
   a_clear_discards: assert property (@(posedge MCLK) disable iff (!rst_n)
      (s_reg.state == trace_pkg::S_FROZEN && CLEAR && !FAULT_RESET)
      |=> !CAPTURED ##1 !CAPTURED)
      else $error("clear did not discard capture");

endmodule // fault_trace_capture

// ---- hw/trace_pkg.sv ----
// Shared constants and types for the fault trace recorder
package trace_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_HZ       = 200_000_000;
   localparam int RATE_FAST_HZ = 16000;
   localparam int RATE_MED_HZ  = 4000;
   localparam int RATE_SLOW_HZ = 1000;
   localparam int DIV_FAST     = CLK_HZ / RATE_FAST_HZ;
   localparam int DIV_MED      = CLK_HZ / RATE_MED_HZ;
   localparam int DIV_SLOW     = CLK_HZ / RATE_SLOW_HZ;

   // ***************************************************************
   // Encodings
   // ***************************************************************
   localparam logic [1:0] RATE_FAST  = 2'h0;
   localparam logic [1:0] RATE_MED   = 2'h1;
   localparam logic [1:0] RATE_SLOW  = 2'h2;
   localparam logic [1:0] MODE_OFF   = 2'h0;
   localparam logic [1:0] MODE_ANY   = 2'h1;
   localparam logic [1:0] MODE_FAULT = 2'h2;
   localparam logic [1:0] MODE_COND  = 2'h3;
   localparam logic       EDGE_RISE  = 1'b0;
   localparam logic       EDGE_FALL  = 1'b1;

   // ***************************************************************
   // Widths and reset values
   // ***************************************************************
   localparam int         CHAN_W      = 16;
   localparam int         CODE_W      = 16;
   localparam int         POS_W       = 7;
   localparam int         POS_FULL    = 100;
   localparam int         MAX_SEL     = 4;
   localparam logic [1:0] RATE_RESET  = RATE_FAST;
   localparam logic [1:0] MODE_RESET  = MODE_ANY;
   localparam logic [6:0] POS_RESET   = 7'h4b;
   localparam logic [15:0] LEVEL_RESET = 16'h0000;
   localparam logic [15:0] CODE_RESET  = 16'h0000;
   localparam logic        EDGE_RESET  = EDGE_RISE;

   typedef enum logic [4:0] {
      S_ARMED  = 5'h01,
      S_POST   = 5'h02,
      S_FROZEN = 5'h04,
      S_READ   = 5'h08,
      S_EMPTY  = 5'h10
   } state_t;

endpackage

// ---- hw/sample_divider.sv ----
// Sample-rate enable divider for the trace recorder
`timescale 1ns/1ps
module sample_divider #(
   parameter int CW       = 18,
   parameter int DIV_FAST = trace_pkg::DIV_FAST,
   parameter int DIV_MED  = trace_pkg::DIV_MED,
   parameter int DIV_SLOW = trace_pkg::DIV_SLOW
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] rate,
   output logic            tick
);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } div_t;

   div_t          s_reg;
   div_t          s_next;
   logic [CW-1:0] lim;

   always_comb begin
      case (rate)
         trace_pkg::RATE_FAST: lim = CW'(DIV_FAST - 1);
         trace_pkg::RATE_MED:  lim = CW'(DIV_MED - 1);
         default:              lim = CW'(DIV_SLOW - 1);
      endcase
      s_next = s_reg;
      // Compare with >= so a rate change mid-period cannot overrun
      s_next.tick = (s_reg.cnt >= lim);
      s_next.cnt  = s_next.tick ? '0 : s_reg.cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

   a_fast_spacing: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && rate == trace_pkg::RATE_FAST) |=> (!tick) [*8])
      else $error("sample ticks too close together");

endmodule // sample_divider

// ---- bench/host_model.sv ----
// Host reader model: accepts readout words promptly or with stalls
`timescale 1ns/1ps
module host_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic slow,
   input  wire logic rd_valid,
   output logic      rd_ready
);
   // ***************************************************************
   // Acceptance pattern
   // ***************************************************************
   logic [3:0] cnt_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_reg <= 4'h0;
      else cnt_reg <= cnt_reg + 4'h1;
   end
   // Slow host is ready only one cycle in four, so held words must survive stalls
   assign rd_ready = rd_valid && (!slow || cnt_reg[1:0] == 2'h3);
endmodule // host_model

// ---- bench/fault_trace_capture_tb_top.sv ----
// Self-checking bench for the fault trace recorder
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin fails++; \
   $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module fault_trace_capture_tb_top;
   // ***************************************************************
   // Signals
   // ***************************************************************
   localparam int NCH = 8;
   localparam int DEPTH = 16;
   // Short dividers keep the run brief; fast must leave 8 idle cycles between ticks
   localparam int DIVS [4] = '{10, 20, 40, 40};
   localparam int PTAB [5] = '{100, 75, 50, 0, 75};
   localparam int RTAB [5] = '{0, 0, 1, 2, 3};
   typedef struct packed {
      logic [2:0]  ch;
      logic [3:0]  idx;
      logic [15:0] d;
      logic        last;
   } note_t;
   logic         MCLK = 1'b0, NRST = 1'b0, FAULT_EVT = 1'b0, FAULT_RESET = 1'b0;
   logic         CFG_LOAD = 1'b0, CFG_EDGE = 1'b0, CLEAR = 1'b0, RD_REQ = 1'b0, RD_ALL = 1'b0;
   logic [127:0] CHAN_DATA = '0;
   logic [15:0]  FAULT_CODE = '0, CFG_FAULT = '0, CFG_LEVEL = '0, RD_DATA;
   logic [1:0]   CFG_RATE = '0, CFG_MODE = 2'h1;
   logic [2:0]   CFG_SRC = '0, RD_CHAN;
   logic [6:0]   CFG_POS = 7'h4b;
   logic [7:0]   RD_SEL = '0;
   logic [3:0]   RD_INDEX;
   logic         RD_READY, RD_VALID, RD_LAST, RD_REJECT, ARMED, CAPTURED;
   logic         slow = 1'b0, rej_seen = 1'b0;
   logic [15:0]  chv [8];
   logic [31:0]  seed = 32'h3b;
   note_t        q [$];
   note_t        n;
   int           fails = 0, checks_done = 0;

   always #2.5 MCLK = ~MCLK;
   fault_trace_capture #(.NCH(NCH), .DEPTH(DEPTH), .DIV_FAST(10), .DIV_MED(20),
      .DIV_SLOW(40)) DUT (
      .MCLK(MCLK), .NRST(NRST), .CHAN_DATA(CHAN_DATA), .FAULT_EVT(FAULT_EVT),
      .FAULT_CODE(FAULT_CODE), .FAULT_RESET(FAULT_RESET), .CFG_LOAD(CFG_LOAD),
      .CFG_RATE(CFG_RATE), .CFG_MODE(CFG_MODE), .CFG_FAULT(CFG_FAULT), .CFG_SRC(CFG_SRC),
      .CFG_LEVEL(CFG_LEVEL), .CFG_EDGE(CFG_EDGE), .CFG_POS(CFG_POS), .CLEAR(CLEAR),
      .RD_REQ(RD_REQ), .RD_ALL(RD_ALL), .RD_SEL(RD_SEL), .RD_READY(RD_READY),
      .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .RD_CHAN(RD_CHAN), .RD_INDEX(RD_INDEX),
      .RD_LAST(RD_LAST), .RD_REJECT(RD_REJECT), .ARMED(ARMED), .CAPTURED(CAPTURED));
   host_model HOST (.clk(MCLK), .rst_n(NRST), .slow(slow), .rd_valid(RD_VALID),
      .rd_ready(RD_READY));

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic stop_test;
      if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge MCLK);
      #1;
   endtask
   task automatic set_ch(input int c, input logic [15:0] v);
      @(posedge MCLK);
      CHAN_DATA[16*c +: 16] <= v;
      chv[c] = v;
   endtask
   task automatic cfg(input logic [1:0] r, m, input logic [15:0] f, lv, input logic e,
                      input logic [6:0] p);
      @(posedge MCLK);
      CFG_LOAD <= 1'b1;
      {CFG_RATE, CFG_MODE, CFG_FAULT, CFG_SRC, CFG_LEVEL, CFG_EDGE, CFG_POS} <=
         {r, m, f, 3'h2, lv, e, p};
      @(posedge MCLK);
      CFG_LOAD <= 1'b0;
   endtask
   task automatic fire(input logic [15:0] c);
      @(posedge MCLK);
      FAULT_EVT <= 1'b1;
      FAULT_CODE <= c;
      @(posedge MCLK);
      FAULT_EVT <= 1'b0;
   endtask
   task automatic rearm;
      @(posedge MCLK);
      FAULT_RESET <= 1'b1;
      @(posedge MCLK);
      FAULT_RESET <= 1'b0;
      cyc(1);
      `CHK("armed", 1'b1, ARMED)
      `CHK("captured", 1'b0, CAPTURED)
   endtask
   task automatic cmd(input logic clr, rq, all, input logic [7:0] sel);
      @(posedge MCLK);
      {CLEAR, RD_REQ, RD_ALL, RD_SEL} <= {clr, rq, all, sel};
      @(posedge MCLK);
      {CLEAR, RD_REQ} <= 2'h0;
   endtask
   task automatic wait_cap(input int k);
      for (int i = 0; i < k && CAPTURED !== 1'b1; i++) cyc(1);
      if (CAPTURED !== 1'b1) begin
         `CHK("capture in time", 1'b1, CAPTURED)
         stop_test();
      end
   endtask
   task automatic read(input logic all, input logic [7:0] sel);
      for (int i = 0; i < DEPTH; i++)
         for (int c = 0; c < NCH; c++)
            if (all || sel[c]) q.push_back('{c[2:0], i[3:0], chv[c],
               i == DEPTH - 1 && (all ? c == NCH - 1 : (sel >> (c + 1)) == 8'h00)});
      rej_seen = 1'b0;
      cmd(1'b0, 1'b1, all, sel);
      for (int i = 0; i < 3000 && q.size() != 0; i++) cyc(1);
      cyc(4);
      `CHK("words left", 0, q.size())
      if (q.size() != 0) stop_test();
      `CHK("no reject", 1'b0, rej_seen)
      `CHK("kept", 1'b1, CAPTURED)
   endtask

   // ***************************************************************
   // Monitor and sequence
   // ***************************************************************
   always @(posedge MCLK) begin
      if (RD_REJECT === 1'b1) rej_seen <= 1'b1;
      if (RD_VALID === 1'b1 && RD_READY === 1'b1) begin
         n = q.size() != 0 ? q.pop_front() : '1;
         `CHK("read word", n, {RD_CHAN, RD_INDEX, RD_DATA, RD_LAST})
      end
   end
   initial begin
      repeat (60000) @(posedge MCLK);
      `CHK("run time", 1'b1, 1'b0)
      stop_test();
   end
   initial begin
      repeat (16) @(posedge MCLK);
      NRST <= 1'b1;
      cyc(3);
      `CHK("armed at start", 1'b1, ARMED)
      `CHK("empty at start", 1'b0, CAPTURED)
      for (int c = 0; c < NCH; c++) begin
         seed = xs(seed);
         set_ch(c, seed[15:0]);
      end
      cyc(200);
      fire(16'h0101);
      cyc(1);
      `CHK("disarmed", 1'b0, ARMED)
      wait_cap(60);
      fire(16'h0102);
      cyc(2);
      `CHK("stays disarmed", 1'b0, ARMED)
      read(1'b1, 8'h00);
      slow = 1'b1;
      read(1'b0, 8'h96);
      for (int i = 0; i < 2; i++) begin
         rej_seen = 1'b0;
         cmd(1'b0, 1'b1, 1'b0, i == 0 ? 8'h1f : 8'h00);
         cyc(3);
         `CHK("reject", 1'b1, rej_seen)
      end
      cmd(1'b1, 1'b0, 1'b0, 8'h00);
      cyc(1);
      `CHK("cleared", 1'b0, CAPTURED)
      `CHK("off after clear", 1'b0, ARMED)
      rej_seen = 1'b0;
      cmd(1'b0, 1'b1, 1'b1, 8'h00);
      cyc(20);
      `CHK("read when empty", 1'b0, rej_seen)
      rearm();
      cfg(trace_pkg::RATE_FAST, trace_pkg::MODE_OFF, 16'h0000, 16'h0000, 1'b0, 7'h4b);
      fire(16'h0101);
      cyc(100);
      `CHK("mode off", 1'b1, ARMED)
      seed = xs(seed);
      cfg(trace_pkg::RATE_MED, trace_pkg::MODE_FAULT, seed[15:0], 16'h0000, 1'b0, 7'h4b);
      fire(seed[15:0] ^ 16'h0001);
      cyc(20);
      `CHK("other sub-code", 1'b1, ARMED)
      fire(seed[15:0]);
      wait_cap(100);
      for (int i = 0; i < 5; i++) begin
         int post;
         int dv;
         post = DEPTH - DEPTH * PTAB[i] / 100;
         dv = DIVS[RTAB[i]];
         cfg(2'(RTAB[i]), trace_pkg::MODE_ANY, 16'h0000, 16'h0000, 1'b0, 7'(PTAB[i]));
         rearm();
         fire(16'h0101);
         // A zero post window freezes on the trigger edge, seen one cycle later
         cyc(post > 0 ? (post - 1) * dv : 1);
         `CHK("post window", post == 0, CAPTURED)
         wait_cap(2 * dv + 4);
      end
      for (int e = 0; e < 2; e++) begin
         logic [15:0] v0;
         v0 = e == 0 ? 16'h8000 : 16'h7fff;
         set_ch(2, v0);
         cfg(trace_pkg::RATE_FAST, trace_pkg::MODE_COND, 16'h0000, 16'h8000, e[0], 7'h4b);
         rearm();
         cyc(20);
         set_ch(2, ~v0);
         cyc(20);
         `CHK("wrong edge", 1'b1, ARMED)
         set_ch(2, v0);
         cyc(20);
         `CHK("edge fire", 1'b0, ARMED)
      end
      stop_test();
   end
endmodule // fault_trace_capture_tb_top
